//--- fpec_pkg.sv
// Package with register map, field positions, reset values and shared types
package fpec_pkg;
    localparam logic [1:0] FPEC_ADDR_MODE = 2'h0;
    localparam logic [1:0] FPEC_ADDR_SETUP = 2'h1;
    localparam logic [1:0] FPEC_ADDR_BSEL_HI = 2'h2;
    localparam logic [1:0] FPEC_ADDR_BSEL_LO = 2'h3;
    localparam int FPEC_MODE_HWP = 7;
    localparam int FPEC_MODE_SWP = 6;
    localparam int FPEC_MODE_EV = 3;
    localparam int FPEC_MODE_PV = 2;
    localparam int FPEC_MODE_E = 1;
    localparam int FPEC_MODE_P = 0;
    localparam int FPEC_SETUP_FAULT = 7;
    localparam int FPEC_SETUP_WIPE = 1;
    localparam int FPEC_SETUP_WRITE = 0;
    localparam logic [7:0] FPEC_MODE_RESET = 8'h80;
    localparam logic [7:0] FPEC_SETUP_RESET = 8'h00;
    localparam logic [7:0] FPEC_BSEL_RESET = 8'h00;
    localparam logic [7:0] FPEC_MODE_WMASK = 8'h4f;
    localparam logic [7:0] FPEC_SETUP_WMASK = 8'h03;

    typedef enum logic [2:0] {
        FPEC_ST_READ = 3'h0,
        FPEC_ST_PSETUP = 3'h1,
        FPEC_ST_PROG = 3'h3,
        FPEC_ST_PVER = 3'h2,
        FPEC_ST_ESETUP = 3'h6,
        FPEC_ST_ERASE = 3'h7,
        FPEC_ST_EVER = 3'h5,
        FPEC_ST_PROT = 3'h4
    } fpec_state_t;

    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } fpec_bus_t;

    typedef struct packed {
        logic hw_standby;
        logic low_power;
        logic gate;
        logic fail;
    } fpec_sys_t;
endpackage

//--- fpec_sync.sv
// Two-flop synchroniser for one level
`timescale 1ns/1ps
`default_nettype none
module fpec_sync (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Level in and out
    input wire logic din,
    output logic dout
);
    typedef struct packed {
        logic s1;
        logic s2;
    } fpec_sync_state_t;

    fpec_sync_state_t st;
    fpec_sync_state_t next_st;

    always_comb begin
        next_st.s1 = din;
        next_st.s2 = st.s1;
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign dout = st.s2;
endmodule
`default_nettype wire

//--- fpec_regfile.sv
// Erase block select pair, cleared when writing is not permitted
`timescale 1ns/1ps
`default_nettype none
module fpec_regfile
    import fpec_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Control
    input wire logic clear,
    input wire logic wr_hi,
    input wire logic wr_lo,
    input wire logic [7:0] wdata,
    // Contents
    output logic [7:0] bsel_hi,
    output logic [7:0] bsel_lo
);
    typedef struct packed {
        logic [7:0] hi;
        logic [7:0] lo;
    } fpec_rf_state_t;

    fpec_rf_state_t st;
    fpec_rf_state_t next_st;

    always_comb begin
        next_st = st;
        if (wr_hi) begin
            next_st.hi = wdata;
        end
        if (wr_lo) begin
            next_st.lo = wdata;
        end
        // More than one block selected clears them all
        if ($countones({next_st.hi, next_st.lo}) > 1) begin
            next_st = '0;
        end
        if (clear) begin
            next_st.hi = FPEC_BSEL_RESET;
            next_st.lo = FPEC_BSEL_RESET;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign bsel_hi = st.hi;
    assign bsel_lo = st.lo;
endmodule
`default_nettype wire

//--- fpec_top.sv
// Flash program and erase control registers with mode sequencing
// What this block does
// - Mode control loads 80 hex on reset, standby and low-power entry.
// - Hardware write permit bit 7 is read-only; writes never change it.
// - Software write permit bit 6 enables program and erase.
// - With software permit clear, check, program, erase, prepare, block bits cannot set.
// - Mode control bits 5 and 4 read zero, unaffected by writes.
// - Bit 3 with permit enters erase check; clearing it leaves.
// - Bit 2 with permit enters program check; clearing it leaves.
// - Bit 1 enters erase only with permit and wipe prepare set.
// - Bit 0 enters program only with permit and write prepare set.
// - Setup register loads 00 on reset and hardware standby.
// - Prepare bits clear on low-power entry or when permit clears.
// - Fault flag bit 7 read-only, set on failure during program or erase, enters protection.
// - Setup bit 1 with permit enters wipe prepare; clearing cancels.
// - Setup bit 0 with permit enters write prepare; clearing cancels.
// - Registers reachable only while the flash register gate is set.
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module fpec_top
    import fpec_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Register port
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // System mode and gate
    input wire logic hw_standby,
    input wire logic low_power,
    input wire logic flash_register_gate,
    input wire logic flash_fail,
    // Flash array controls
    output logic flash_program,
    output logic flash_erase,
    output logic flash_program_check,
    output logic flash_erase_check,
    output logic flash_protected,
    output logic [2:0] flash_state
);
    typedef struct packed {
        logic [7:0] mode;
        logic [7:0] setup;
        logic [7:0] rdata;
        logic lp_d;
        fpec_state_t state;
        logic prog;
        logic erase;
        logic pchk;
        logic echk;
    } fpec_top_state_t;

    fpec_top_state_t st;
    fpec_top_state_t next_st;
    fpec_bus_t bus;
    fpec_sys_t sys;
    logic hwsb_s;
    logic lp_s;
    logic fail_s;
    logic [7:0] bsel_hi;
    logic [7:0] bsel_lo;
    logic bsel_clear;
    logic bsel_wr_hi;
    logic bsel_wr_lo;
    logic lp_entry;

    // Asynchronous mode and fault levels come from other logic domains
    fpec_sync u_sync_hwsb (
        .mclk(mclk),
        .resetn(resetn),
        .din(hw_standby),
        .dout(hwsb_s)
    );
    fpec_sync u_sync_lp (
        .mclk(mclk),
        .resetn(resetn),
        .din(low_power),
        .dout(lp_s)
    );
    fpec_sync u_sync_fail (
        .mclk(mclk),
        .resetn(resetn),
        .din(flash_fail),
        .dout(fail_s)
    );

    always_comb begin
        bus.addr = reg_addr;
        bus.wdata = reg_wdata;
        bus.wr = reg_wr;
        bus.rd = reg_rd;
        sys.hw_standby = hwsb_s;
        sys.low_power = lp_s;
        sys.gate = flash_register_gate;
        sys.fail = fail_s;
    end

    assign lp_entry = sys.low_power & ~st.lp_d;
    assign bsel_clear = sys.hw_standby | lp_entry | ~st.mode[FPEC_MODE_SWP];
    assign bsel_wr_hi = bus.wr & sys.gate & (bus.addr == FPEC_ADDR_BSEL_HI);
    assign bsel_wr_lo = bus.wr & sys.gate & (bus.addr == FPEC_ADDR_BSEL_LO);

    fpec_regfile u_bsel (
        .mclk(mclk),
        .resetn(resetn),
        .clear(bsel_clear),
        .wr_hi(bsel_wr_hi),
        .wr_lo(bsel_wr_lo),
        .wdata(bus.wdata),
        .bsel_hi(bsel_hi),
        .bsel_lo(bsel_lo)
    );

    always_comb begin
        logic [7:0] wv;
        logic swp;
        logic blocked;
        wv = bus.wdata;
        swp = st.mode[FPEC_MODE_SWP];
        blocked = 1'b0;
        next_st = st;
        next_st.lp_d = sys.low_power;
        // Mode control write
        if (bus.wr && sys.gate && bus.addr == FPEC_ADDR_MODE) begin
            swp = wv[FPEC_MODE_SWP];
            next_st.mode[FPEC_MODE_SWP] = swp;
            // Dependent bits only take a one while permit is already set
            next_st.mode[FPEC_MODE_EV] = wv[FPEC_MODE_EV] & st.mode[FPEC_MODE_SWP];
            next_st.mode[FPEC_MODE_PV] = wv[FPEC_MODE_PV] & st.mode[FPEC_MODE_SWP];
            next_st.mode[FPEC_MODE_E] = wv[FPEC_MODE_E] & st.mode[FPEC_MODE_SWP];
            next_st.mode[FPEC_MODE_P] = wv[FPEC_MODE_P] & st.mode[FPEC_MODE_SWP];
        end
        next_st.mode[FPEC_MODE_HWP] = 1'b1;
        next_st.mode[5:4] = 2'b00;
        // Setup register write; reserved bits held at zero
        if (bus.wr && sys.gate && bus.addr == FPEC_ADDR_SETUP) begin
            next_st.setup[FPEC_SETUP_WIPE] = wv[FPEC_SETUP_WIPE] & st.mode[FPEC_MODE_SWP];
            next_st.setup[FPEC_SETUP_WRITE] = wv[FPEC_SETUP_WRITE] & st.mode[FPEC_MODE_SWP];
        end
        next_st.setup[6:2] = 5'h00;
        // Prepare bits fall with the permit
        if (!next_st.mode[FPEC_MODE_SWP]) begin
            next_st.setup[FPEC_SETUP_WIPE] = 1'b0;
            next_st.setup[FPEC_SETUP_WRITE] = 1'b0;
        end
        // Failure sets fault; set wins over any write
        if (sys.fail && (st.prog || st.erase)) begin
            next_st.setup[FPEC_SETUP_FAULT] = 1'b1;
        end
        if (lp_entry) begin
            next_st.mode = FPEC_MODE_RESET;
            next_st.setup[FPEC_SETUP_WIPE] = 1'b0;
            next_st.setup[FPEC_SETUP_WRITE] = 1'b0;
        end
        if (sys.hw_standby) begin
            next_st.mode = FPEC_MODE_RESET;
            next_st.setup = FPEC_SETUP_RESET;
        end
        // Array drives follow the registered bits
        blocked = next_st.setup[FPEC_SETUP_FAULT];
        next_st.prog = ~blocked & next_st.mode[FPEC_MODE_SWP] & next_st.mode[FPEC_MODE_P]
            & next_st.setup[FPEC_SETUP_WRITE];
        next_st.erase = ~blocked & next_st.mode[FPEC_MODE_SWP] & next_st.mode[FPEC_MODE_E]
            & next_st.setup[FPEC_SETUP_WIPE];
        next_st.pchk = next_st.mode[FPEC_MODE_SWP] & next_st.mode[FPEC_MODE_PV];
        next_st.echk = next_st.mode[FPEC_MODE_SWP] & next_st.mode[FPEC_MODE_EV];
        if (blocked) begin
            next_st.state = FPEC_ST_PROT;
        end else if (next_st.prog) begin
            next_st.state = FPEC_ST_PROG;
        end else if (next_st.erase) begin
            next_st.state = FPEC_ST_ERASE;
        end else if (next_st.pchk) begin
            next_st.state = FPEC_ST_PVER;
        end else if (next_st.echk) begin
            next_st.state = FPEC_ST_EVER;
        end else if (next_st.mode[FPEC_MODE_SWP] && next_st.setup[FPEC_SETUP_WRITE]) begin
            next_st.state = FPEC_ST_PSETUP;
        end else if (next_st.mode[FPEC_MODE_SWP] && next_st.setup[FPEC_SETUP_WIPE]) begin
            next_st.state = FPEC_ST_ESETUP;
        end else begin
            next_st.state = FPEC_ST_READ;
        end
        // Read data one cycle after strobe; ungated reads return zero
        next_st.rdata = 8'h00;
        if (bus.rd && sys.gate) begin
            case (bus.addr)
                FPEC_ADDR_MODE: begin
                    next_st.rdata = st.mode;
                end
                FPEC_ADDR_SETUP: begin
                    next_st.rdata = st.setup;
                end
                FPEC_ADDR_BSEL_HI: begin
                    next_st.rdata = bsel_hi;
                end
                FPEC_ADDR_BSEL_LO: begin
                    next_st.rdata = bsel_lo;
                end
                default: begin
                    next_st.rdata = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st.mode <= FPEC_MODE_RESET;
            st.setup <= FPEC_SETUP_RESET;
            st.rdata <= 8'h00;
            st.lp_d <= 1'b0;
            st.state <= FPEC_ST_READ;
            st.prog <= 1'b0;
            st.erase <= 1'b0;
            st.pchk <= 1'b0;
            st.echk <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata = st.rdata;
    assign flash_program = st.prog;
    assign flash_erase = st.erase;
    assign flash_program_check = st.pchk;
    assign flash_erase_check = st.echk;
    assign flash_protected = st.setup[FPEC_SETUP_FAULT];
    assign flash_state = st.state;
endmodule
`default_nettype wire

//--- fpec_chk.sv
// Concurrent checks on the flash control block ports
`timescale 1ns/1ps
`default_nettype none
module fpec_chk
    import fpec_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Watched ports
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic hw_standby,
    input wire logic flash_register_gate,
    input wire logic flash_fail,
    input wire logic flash_program,
    input wire logic flash_erase,
    input wire logic flash_protected,
    input wire logic [2:0] flash_state
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);
    sequence s_mode_wr;
        reg_wr && flash_register_gate && reg_addr == FPEC_ADDR_MODE;
    endsequence
    // Sync delay on the fail input, so the flag may lag by a few edges
    sequence s_fail_run;
        (flash_fail && (flash_program || flash_erase))[*3];
    endsequence
    chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not zero outside a read");
    chk_mode_fixed: assert property (reg_rd && flash_register_gate && reg_addr == FPEC_ADDR_MODE
        |=> reg_rdata[FPEC_MODE_HWP] && reg_rdata[5:4] == 2'b00)
        else $error("mode fixed bits wrong");
    chk_gated_read: assert property (reg_rd && !flash_register_gate |=> reg_rdata == 8'h00)
        else $error("gated read not zero");
    // Permit must stay set in the same write, or program cannot start
    chk_prog_go: assert property (s_mode_wr ##0 (reg_wdata[FPEC_MODE_P] && !flash_protected
        && reg_wdata[FPEC_MODE_SWP] && flash_state == FPEC_ST_PSETUP) |=> flash_program)
        else $error("program did not start");
    chk_prog_need: assert property ($rose(flash_program)
        |-> $past(flash_state) == FPEC_ST_PSETUP)
        else $error("program without prepare");
    chk_erase_need: assert property ($rose(flash_erase)
        |-> $past(flash_state) == FPEC_ST_ESETUP)
        else $error("erase without prepare");
    chk_fault_set: assert property (s_fail_run |-> ##[0:3] flash_protected)
        else $error("fault flag not set");
    chk_prot_block: assert property (flash_protected && $past(flash_protected)
        |-> !flash_program && !flash_erase)
        else $error("array active while protected");
    chk_prot_hold: assert property (flash_protected && !hw_standby |=> flash_protected)
        else $error("protection dropped");
endmodule
bind fpec_top fpec_chk u_chk (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .hw_standby(hw_standby), .flash_register_gate(flash_register_gate),
    .flash_fail(flash_fail), .flash_program(flash_program), .flash_erase(flash_erase),
    .flash_protected(flash_protected), .flash_state(flash_state));
`default_nettype wire

//--- fpec_top_bench.sv
// Self-checking bench for the flash control block
`timescale 1ns/1ps
`default_nettype none
module fpec_top_bench
    import fpec_pkg::*;
;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic [1:0] addr = 2'h0;
    logic [7:0] wdata = 8'h00;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic [7:0] rdata;
    logic hw_standby = 1'b0;
    logic low_power = 1'b0;
    logic gate = 1'b1;
    logic fail = 1'b0;
    logic prog, erase, pchk, echk, prot;
    logic [2:0] state;
    logic [7:0] d;
    int miscompares = 0;
    int n_tests = 0;

    always #5 mclk = ~mclk;

    fpec_top dut (.mclk(mclk), .resetn(resetn), .reg_addr(addr), .reg_wdata(wdata),
        .reg_wr(wr_s), .reg_rd(rd_s), .reg_rdata(rdata), .hw_standby(hw_standby),
        .low_power(low_power), .flash_register_gate(gate), .flash_fail(fail),
        .flash_program(prog), .flash_erase(erase), .flash_program_check(pchk),
        .flash_erase_check(echk), .flash_protected(prot), .flash_state(state));

    task automatic ck(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic o_ck(input string what, input logic [4:0] bits, input fpec_state_t st);
        ck(what, {bits, st}, {prot, echk, pchk, erase, prog, state});
    endtask

    // Ends 1 ns past the taking edge so registered effects have landed
    task automatic wr(input logic [1:0] a, input logic [7:0] v);
        @(posedge mclk);
        addr <= a;
        wdata <= v;
        wr_s <= 1'b1;
        @(posedge mclk);
        wr_s <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [1:0] a, output logic [7:0] v);
        @(posedge mclk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge mclk);
        rd_s <= 1'b0;
        #1;
        v = rdata;
    endtask

    task automatic t_reset();
        rd(FPEC_ADDR_MODE, d);
        ck("mode", FPEC_MODE_RESET, d);
        rd(FPEC_ADDR_SETUP, d);
        ck("setup", FPEC_SETUP_RESET, d);
        o_ck("idle", 5'h00, FPEC_ST_READ);
        $display("reset test done");
    endtask

    task automatic t_access();
        wr(FPEC_ADDR_MODE, 8'hff);
        rd(FPEC_ADDR_MODE, d);
        ck("mode", 8'hc0, d);
        @(posedge mclk) gate <= 1'b0;
        wr(FPEC_ADDR_MODE, 8'h80);
        rd(FPEC_ADDR_MODE, d);
        ck("gated", 8'h00, d);
        @(posedge mclk) gate <= 1'b1;
        rd(FPEC_ADDR_MODE, d);
        ck("mode", 8'hc0, d);
        $display("access test done");
    endtask

    task automatic t_modes();
        logic [7:0] su [2] = '{8'h01, 8'h02};
        fpec_state_t pst [2] = '{FPEC_ST_PSETUP, FPEC_ST_ESETUP};
        fpec_state_t gst [2] = '{FPEC_ST_PROG, FPEC_ST_ERASE};
        fpec_state_t vst [2] = '{FPEC_ST_PVER, FPEC_ST_EVER};
        for (int i = 0; i < 2; i++) begin
            wr(FPEC_ADDR_MODE, 8'h40 | su[i]);
            o_ck("no prepare", 5'h00, FPEC_ST_READ);
            wr(FPEC_ADDR_MODE, 8'h40);
            wr(FPEC_ADDR_SETUP, su[i]);
            o_ck("prepare", 5'h00, pst[i]);
            wr(FPEC_ADDR_MODE, 8'h40 | su[i]);
            o_ck("active", su[i][4:0], gst[i]);
            wr(FPEC_ADDR_MODE, 8'h40);
            o_ck("stopped", 5'h00, pst[i]);
            wr(FPEC_ADDR_SETUP, 8'h00);
            o_ck("cancel", 5'h00, FPEC_ST_READ);
            wr(FPEC_ADDR_MODE, 8'h40 | (su[i] << 2));
            o_ck("verify", su[i][2:0] * 5'h04, vst[i]);
            wr(FPEC_ADDR_MODE, 8'h40);
            o_ck("verify off", 5'h00, FPEC_ST_READ);
        end
        $display("mode test done");
    endtask

    task automatic t_permit();
        wr(FPEC_ADDR_BSEL_LO, 8'h01);
        rd(FPEC_ADDR_BSEL_LO, d);
        ck("bsel", 8'h01, d);
        wr(FPEC_ADDR_BSEL_LO, 8'h03);
        rd(FPEC_ADDR_BSEL_LO, d);
        ck("bsel two", 8'h00, d);
        wr(FPEC_ADDR_BSEL_HI, 8'h02);
        rd(FPEC_ADDR_BSEL_HI, d);
        ck("bsel high", 8'h02, d);
        wr(FPEC_ADDR_SETUP, 8'h02);
        wr(FPEC_ADDR_MODE, 8'h00);
        rd(FPEC_ADDR_SETUP, d);
        ck("setup", 8'h00, d);
        wr(FPEC_ADDR_SETUP, 8'h01);
        wr(FPEC_ADDR_BSEL_HI, 8'h01);
        o_ck("locked", 5'h00, FPEC_ST_READ);
        rd(FPEC_ADDR_BSEL_HI, d);
        ck("bsel", 8'h00, d);
        $display("permit test done");
    endtask

    task automatic t_low_power();
        wr(FPEC_ADDR_MODE, 8'h40);
        wr(FPEC_ADDR_SETUP, 8'h01);
        @(posedge mclk) low_power <= 1'b1;
        repeat (6) @(posedge mclk);
        low_power <= 1'b0;
        rd(FPEC_ADDR_MODE, d);
        ck("mode", FPEC_MODE_RESET, d);
        rd(FPEC_ADDR_SETUP, d);
        ck("setup", 8'h00, d);
        $display("low power test done");
    endtask

    task automatic t_fault();
        wr(FPEC_ADDR_MODE, 8'h40);
        wr(FPEC_ADDR_SETUP, 8'h01);
        wr(FPEC_ADDR_MODE, 8'h41);
        @(posedge mclk) fail <= 1'b1;
        repeat (6) @(posedge mclk);
        fail <= 1'b0;
        #1;
        o_ck("fault", 5'h10, FPEC_ST_PROT);
        rd(FPEC_ADDR_SETUP, d);
        ck("flag", 8'h80, d & 8'h80);
        wr(FPEC_ADDR_MODE, 8'h40);
        wr(FPEC_ADDR_MODE, 8'h41);
        o_ck("blocked", 5'h10, FPEC_ST_PROT);
        @(posedge mclk) hw_standby <= 1'b1;
        repeat (4) @(posedge mclk);
        hw_standby <= 1'b0;
        repeat (4) @(posedge mclk);
        rd(FPEC_ADDR_SETUP, d);
        ck("setup", FPEC_SETUP_RESET, d);
        rd(FPEC_ADDR_MODE, d);
        ck("mode", FPEC_MODE_RESET, d);
        o_ck("cleared", 5'h00, FPEC_ST_READ);
        $display("fault test done");
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        t_reset();
        t_access();
        t_modes();
        t_permit();
        t_low_power();
        t_fault();
        conclude();
    end

    // Whole run is about 120 cycles; 5000 leaves ample room
    initial begin
        #50000;
        miscompares++;
        conclude();
    end
endmodule
`default_nettype wire
